//--- hdl/cdg_pkg.sv
// package: register indices, field positions and reset values of the card detect control bank
package cdg_pkg;
   //------------------------------------------------------------
   // register indices
   //------------------------------------------------------------
   localparam logic [7:0] CDG_IDX_CDGC_A  = 8'h16; // socket a card detect / general control
   localparam logic [7:0] CDG_IDX_CDGC_B  = 8'h56; // socket b card detect / general control
   localparam logic [7:0] CDG_IDX_GLOBAL  = 8'h1e; // shared global socket control
   //------------------------------------------------------------
   // card detect / general control fields
   //------------------------------------------------------------
   localparam int         CDG_BIT_SENSE2  = 7;
   localparam int         CDG_BIT_SENSE1  = 6;
   localparam int         CDG_BIT_SOFT    = 5;
   localparam int         CDG_BIT_WAKE_EN = 4;
   localparam int         CDG_BIT_RM_EN   = 1;
   localparam logic       CDG_WAKE_EN_RST = 1'b0;
   localparam logic       CDG_RM_EN_RST   = 1'b0;
   //------------------------------------------------------------
   // global control fields
   //------------------------------------------------------------
   localparam int         CDG_BIT_FLAG_CLR = 2;
   localparam logic [7:0] CDG_GLOBAL_MASK  = 8'h1f; // bits 7..5 read only zero
   localparam logic [7:0] CDG_GLOBAL_RST   = 8'h00;
   localparam int         CDG_SOCKETS      = 2;
endpackage

//--- hdl/cdg_socket.sv
// per-socket card detect, voltage sense, wake and removal-reset logic
`timescale 1ns/1ps
module cdg_socket
   import cdg_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // register write from the bank
   input  wire logic       cfg_wr,
   input  wire logic [7:0] wdata,
   // status-change side
   input  wire logic       cd_int_en,
   input  wire logic       cd_flag_clear,
   input  wire logic       status_bit3_wr1,
   input  wire logic       flag_clear_mode,
   // slot pins
   input  wire logic       detect_pin_one,
   input  wire logic       detect_pin_two,
   input  wire logic       voltage_sense_one,
   input  wire logic       voltage_sense_two,
   // results
   output logic      [7:0] rd_value,
   output logic            soft_irq,
   output logic            wake_low,
   output logic            removal_pulse
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   logic       wake_en_q, wake_en_d;
   logic       rm_en_q, rm_en_d;
   logic       soft_q, soft_d;
   logic [1:0] det_q, det_d;
   logic       det_seen_q, det_seen_d;
   logic       wake_q, wake_d;
   logic       rm_q, rm_d;
   logic [1:0] det_now;
   logic       cd_change;

   assign det_now   = {detect_pin_two, detect_pin_one};
   // no change is claimed before the first sample after reset
   assign cd_change = det_seen_q && (det_q != det_now);

   // next-state computation
   always_comb begin
      wake_en_d  = wake_en_q;
      rm_en_d    = rm_en_q;
      if (cfg_wr) begin
         wake_en_d = wdata[CDG_BIT_WAKE_EN];
         rm_en_d   = wdata[CDG_BIT_RM_EN];
      end
      // trigger lives one cycle only; a global flag clear in the same cycle does not drop it
      soft_d = 1'b0;
      if (flag_clear_mode && status_bit3_wr1)
         soft_d = 1'b0;
      if (cfg_wr && wdata[CDG_BIT_SOFT] && cd_int_en)
         soft_d = 1'b1;
      det_d      = det_now;
      det_seen_d = 1'b1;
      // set wins over the flag clear so a change in that cycle is kept
      wake_d = (wake_en_q && cd_change) || (wake_q && !cd_flag_clear);
      // removal: both pins were low (card seated) and one has gone high
      rm_d = rm_en_q && det_seen_q && (det_q == 2'b00) && (det_now != 2'b00);
   end

   // registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_en_q  <= CDG_WAKE_EN_RST;
         rm_en_q    <= CDG_RM_EN_RST;
         soft_q     <= 1'b0;
         det_q      <= 2'b00;
         det_seen_q <= 1'b0;
         wake_q     <= 1'b0;
         rm_q       <= 1'b0;
      end else begin
         wake_en_q  <= wake_en_d;
         rm_en_q    <= rm_en_d;
         soft_q     <= soft_d;
         det_q      <= det_d;
         det_seen_q <= det_seen_d;
         wake_q     <= wake_d;
         rm_q       <= rm_d;
      end
   end

   // read image: live sense levels, trigger and reserved bits as zero
   assign rd_value = {voltage_sense_two, voltage_sense_one, 1'b0, wake_en_q,
                      2'b00, rm_en_q, 1'b0};
   assign soft_irq      = soft_q;
   assign wake_low      = wake_q;
   assign removal_pulse = rm_q;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   AST_SOFT_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
      cfg_wr && wdata[CDG_BIT_SOFT] && cd_int_en |=> soft_q)
      else $error("soft trigger did not raise interrupt");
   AST_SOFT_NOEN: assert property (@(posedge clk) disable iff (!arst_n)
      soft_q |-> $past(cd_int_en) && $past(cfg_wr))
      else $error("soft interrupt without enable or write");
   AST_SOFT_SELF: assert property (@(posedge clk) disable iff (!arst_n)
      soft_q && !(cfg_wr && wdata[CDG_BIT_SOFT] && cd_int_en) |=> !soft_q)
      else $error("soft trigger did not clear itself");
   AST_WAKE_SET: assert property (@(posedge clk) disable iff (!arst_n)
      wake_en_q && cd_change |=> wake_q)
      else $error("wake not driven on detect change");
   AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      wake_q && !cd_flag_clear |=> wake_q)
      else $error("wake released without flag clear");
   AST_RM_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
      rm_q |-> $past(rm_en_q) && ($past(det_q) == 2'b00))
      else $error("removal reset without enable or seated card");
   COV_SOFT: cover property (@(posedge clk) disable iff (!arst_n) soft_q);
   COV_WAKE: cover property (@(posedge clk) disable iff (!arst_n) wake_q ##1 !wake_q);
   COV_RM:   cover property (@(posedge clk) disable iff (!arst_n) rm_q);
endmodule

//--- hdl/cdg_top.sv
// card detect and general control bank for two sockets plus the shared global control
`timescale 1ns/1ps
module cdg_top
   import cdg_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // indexed register port
   input  wire logic [7:0]             reg_idx,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_wdata,
   output logic      [7:0]             reg_rdata,
   output logic                        reg_rvalid,
   // status-change register side, one bit per socket
   input  wire logic [CDG_SOCKETS-1:0] cd_int_en,
   input  wire logic [CDG_SOCKETS-1:0] cd_flag_clear,
   input  wire logic [CDG_SOCKETS-1:0] status_bit3_wr1,
   // slot pins, one bit per socket
   input  wire logic [CDG_SOCKETS-1:0] detect_pin_one,
   input  wire logic [CDG_SOCKETS-1:0] detect_pin_two,
   input  wire logic [CDG_SOCKETS-1:0] voltage_sense_one,
   input  wire logic [CDG_SOCKETS-1:0] voltage_sense_two,
   // outputs toward the interrupt, wake and compatibility logic
   output logic      [CDG_SOCKETS-1:0] soft_cd_irq,
   output logic      [CDG_SOCKETS-1:0] compat_reset,
   output logic                        ring_wake_out_n,
   output logic      [7:0]             global_ctrl,
   output logic                        flag_clear_mode
);
   //------------------------------------------------------------
   // shared global control
   //------------------------------------------------------------
   logic [7:0]             global_q, global_d;
   logic [7:0]             rdata_q, rdata_d;
   logic                   rvalid_q, rvalid_d;
   logic [CDG_SOCKETS-1:0] irq_q, irq_d;
   logic [CDG_SOCKETS-1:0] crst_q, crst_d;
   logic                   wake_n_q, wake_n_d;
   logic [CDG_SOCKETS-1:0] sock_wr;
   logic [CDG_SOCKETS-1:0] sock_irq;
   logic [CDG_SOCKETS-1:0] sock_wake;
   logic [CDG_SOCKETS-1:0] sock_rm;
   logic [7:0]             sock_rd [CDG_SOCKETS];

   // writes touch only the five low bits; the top three stay zero
   always_comb begin
      global_d = global_q;
      if (reg_wr && reg_idx == CDG_IDX_GLOBAL)
         global_d = reg_wdata & CDG_GLOBAL_MASK;
   end

   //------------------------------------------------------------
   // socket instances
   //------------------------------------------------------------
   assign sock_wr[0] = reg_wr && (reg_idx == CDG_IDX_CDGC_A);
   assign sock_wr[1] = reg_wr && (reg_idx == CDG_IDX_CDGC_B);

   // one copy per socket, sharing only clock, reset, write data and the global clear mode
   genvar s;
   generate
      for (s = 0; s < CDG_SOCKETS; s++) begin : g_sock
         cdg_socket cdg_socket_inst (
            .clk               (clk),
            .arst_n            (arst_n),
            .cfg_wr            (sock_wr[s]),
            .wdata             (reg_wdata),
            .cd_int_en         (cd_int_en[s]),
            .cd_flag_clear     (cd_flag_clear[s]),
            .status_bit3_wr1   (status_bit3_wr1[s]),
            .flag_clear_mode   (global_q[CDG_BIT_FLAG_CLR]),
            .detect_pin_one    (detect_pin_one[s]),
            .detect_pin_two    (detect_pin_two[s]),
            .voltage_sense_one (voltage_sense_one[s]),
            .voltage_sense_two (voltage_sense_two[s]),
            .rd_value          (sock_rd[s]),
            .soft_irq          (sock_irq[s]),
            .wake_low          (sock_wake[s]),
            .removal_pulse     (sock_rm[s])
         );
      end
   endgenerate

   //------------------------------------------------------------
   // read path and output staging
   //------------------------------------------------------------
   // read data lands one cycle after the strobe; unknown indices read zero
   always_comb begin
      rdata_d  = 8'h00;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         case (reg_idx)
            CDG_IDX_CDGC_A: rdata_d = sock_rd[0];
            CDG_IDX_CDGC_B: rdata_d = sock_rd[1];
            CDG_IDX_GLOBAL: rdata_d = global_q;
            default:        rdata_d = 8'h00;
         endcase
      end
      irq_d    = sock_irq;
      crst_d   = sock_rm;
      // wake pin is shared: either socket pulls it low
      wake_n_d = ~|sock_wake;
   end

   // registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         global_q <= CDG_GLOBAL_RST;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
         irq_q    <= '0;
         crst_q   <= '0;
         wake_n_q <= 1'b1;
      end else begin
         global_q <= global_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         irq_q    <= irq_d;
         crst_q   <= crst_d;
         wake_n_q <= wake_n_d;
      end
   end

   assign reg_rdata       = rdata_q;
   assign reg_rvalid      = rvalid_q;
   assign soft_cd_irq     = irq_q;
   assign compat_reset    = crst_q;
   assign ring_wake_out_n = wake_n_q;
   assign global_ctrl     = global_q;
   // the status-change register uses this to choose read-clear or write-back
   assign flag_clear_mode = global_q[CDG_BIT_FLAG_CLR];

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   AST_SENSE_RD: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd && reg_idx == CDG_IDX_CDGC_A |=>
         reg_rdata[CDG_BIT_SENSE2] == $past(voltage_sense_two[0]) &&
         reg_rdata[CDG_BIT_SENSE1] == $past(voltage_sense_one[0]))
      else $error("sense bits not read live");
   AST_RSVD_RD: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd && reg_idx == CDG_IDX_CDGC_B |=>
         reg_rdata[CDG_BIT_SOFT] == 1'b0 && reg_rdata[3:2] == 2'b00 && reg_rdata[0] == 1'b0)
      else $error("reserved or write-only bits read nonzero");
   AST_GLOBAL_RO: assert property (@(posedge clk) disable iff (!arst_n)
      global_q[7:5] == 3'b000)
      else $error("global read-only bits nonzero");
   AST_GLOBAL_WR: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr && reg_idx == CDG_IDX_GLOBAL |=> global_q[4:0] == $past(reg_wdata[4:0]))
      else $error("global write not stored");
   AST_WAKE_PIN: assert property (@(posedge clk) disable iff (!arst_n)
      !ring_wake_out_n && !(|(cd_flag_clear & sock_wake)) && (sock_wake != '0) |=>
         !ring_wake_out_n)
      else $error("ring wake released early");
   AST_IRQ_STAGE: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr && reg_idx == CDG_IDX_CDGC_A && reg_wdata[CDG_BIT_SOFT] && cd_int_en[0]
         |-> ##2 soft_cd_irq[0])
      else $error("soft interrupt did not reach output");
   AST_IRQ_STAGE_B: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr && reg_idx == CDG_IDX_CDGC_B && reg_wdata[CDG_BIT_SOFT] && cd_int_en[1]
         |-> ##2 soft_cd_irq[1])
      else $error("socket b soft interrupt did not reach output");
   // a pulse at the pin must trace back to an enabled trigger two edges earlier
   AST_IRQ_NOEN: assert property (@(posedge clk) disable iff (!arst_n)
      soft_cd_irq[0] |-> $past(cd_int_en[0], 2))
      else $error("soft interrupt raised while disabled");
   AST_SENSE_RD_B: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd && reg_idx == CDG_IDX_CDGC_B |=>
         reg_rdata[CDG_BIT_SENSE2] == $past(voltage_sense_two[1]) &&
         reg_rdata[CDG_BIT_SENSE1] == $past(voltage_sense_one[1]))
      else $error("socket b sense bits not read live");
   AST_RSVD_RD_A: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd && reg_idx == CDG_IDX_CDGC_A |=>
         reg_rdata[CDG_BIT_SOFT] == 1'b0 && reg_rdata[3:2] == 2'b00 && reg_rdata[0] == 1'b0)
      else $error("socket a reserved or write-only bits read nonzero");
   // only a write to its own index may move the shared global byte
   AST_GLOBAL_KEEP: assert property (@(posedge clk) disable iff (!arst_n)
      !(reg_wr && reg_idx == CDG_IDX_GLOBAL) |=> $stable(global_q))
      else $error("global control changed without a write");
   AST_CLR_MODE: assert property (@(posedge clk) disable iff (!arst_n)
      flag_clear_mode == global_ctrl[CDG_BIT_FLAG_CLR])
      else $error("flag clear mode not taken from global bit");
   // removal pulse is staged through one flop toward the pin
   AST_RM_STAGE: assert property (@(posedge clk) disable iff (!arst_n)
      sock_rm[0] |=> compat_reset[0])
      else $error("removal reset did not reach output");
   // released one cycle after no socket holds its wake request
   AST_WAKE_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      sock_wake == '0 |=> ring_wake_out_n)
      else $error("ring wake held with no socket asking");

   //------------------------------------------------------------
   // read handshake checks
   //------------------------------------------------------------
   // read answers come one cycle after the strobe and never linger
   AST_RVALID_ONE: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd |=> reg_rvalid)
      else $error("read strobe not answered");
   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
      else $error("read data left standing");

   //------------------------------------------------------------
   // coverage
   //------------------------------------------------------------
   COV_GLOBAL_WR: cover property (@(posedge clk) disable iff (!arst_n)
      reg_wr && reg_idx == CDG_IDX_GLOBAL);
   COV_WAKE_LOW:  cover property (@(posedge clk) disable iff (!arst_n) !ring_wake_out_n);
endmodule

//--- bench/cdg_slot_model.sv
// slot model: card detect and voltage sense pins of two card sockets
`timescale 1ns/1ps
module cdg_slot_model
   import cdg_pkg::*;
(
   // card state requested by the bench
   input  wire logic [CDG_SOCKETS-1:0] seated,
   input  wire logic [CDG_SOCKETS-1:0] sense1_set,
   input  wire logic [CDG_SOCKETS-1:0] sense2_set,
   // slot pins
   output logic      [CDG_SOCKETS-1:0] detect_pin_one,
   output logic      [CDG_SOCKETS-1:0] detect_pin_two,
   output logic      [CDG_SOCKETS-1:0] voltage_sense_one,
   output logic      [CDG_SOCKETS-1:0] voltage_sense_two
);
   // a seated card grounds both detect pins; an empty slot is lifted by pull-ups
   assign detect_pin_one    = ~seated;
   assign detect_pin_two    = ~seated;
   // sense pins carry the card coding, pulled high once the card is gone
   assign voltage_sense_one = sense1_set | ~seated;
   assign voltage_sense_two = sense2_set | ~seated;
endmodule

//--- bench/tb_cdg_top.sv
// self-checking bench for the card detect and general control bank
`timescale 1ns/1ps
module tb_cdg_top;
   import cdg_pkg::*;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [7:0] reg_idx, reg_wdata, reg_rdata, global_ctrl;
   logic       reg_wr, reg_rd, reg_rvalid, ring_wake_out_n, flag_clear_mode;
   logic [1:0] cd_int_en, cd_flag_clear, status_bit3_wr1, seated, sense1_set, sense2_set;
   logic [1:0] det1, det2, sense1, sense2, soft_cd_irq, compat_reset;
   logic [7:0] irq_cnt, rm_cnt, hi_cnt;
   int         err_count = 0;
   int         checks_done = 0;

   always #2 clk = ~clk;

   cdg_slot_model cdg_slot_model_inst (.seated(seated),
      .sense1_set(sense1_set), .sense2_set(sense2_set),
      .detect_pin_one(det1), .detect_pin_two(det2),
      .voltage_sense_one(sense1), .voltage_sense_two(sense2));

   cdg_top cdg_top_inst (.clk(clk), .arst_n(arst_n), .reg_idx(reg_idx), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cd_int_en(cd_int_en), .cd_flag_clear(cd_flag_clear), .status_bit3_wr1(status_bit3_wr1),
      .detect_pin_one(det1), .detect_pin_two(det2), .voltage_sense_one(sense1),
      .voltage_sense_two(sense2), .soft_cd_irq(soft_cd_irq), .compat_reset(compat_reset),
      .ring_wake_out_n(ring_wake_out_n), .global_ctrl(global_ctrl),
      .flag_clear_mode(flag_clear_mode));

   //------------------------------------------------------------
   // shared tasks
   //------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
      end
   endtask

   // strobes rise and fall on falling edges so the rising edge sees them settled
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      @(negedge clk);
      reg_idx = idx;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
      @(negedge clk);
      reg_idx = idx;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid}, 8'h01, "read valid");
      chk(reg_rdata, exp, what);
   endtask

   // counts pulses per socket (a low nibble, b high nibble) and cycles of wake high
   task automatic watch(input int n);
      irq_cnt = 8'h00;
      rm_cnt = 8'h00;
      hi_cnt = 8'h00;
      repeat (n) begin
         @(negedge clk);
         irq_cnt = irq_cnt + {3'h0, soft_cd_irq[1], 3'h0, soft_cd_irq[0]};
         rm_cnt = rm_cnt + {3'h0, compat_reset[1], 3'h0, compat_reset[0]};
         hi_cnt = hi_cnt + {7'h00, ring_wake_out_n};
      end
   endtask

   // bounded wait for the wake line; running out of cycles ends the run
   task automatic clear_and_wait_high();
      int i;
      @(negedge clk);
      cd_flag_clear = 2'b01;
      @(negedge clk);
      cd_flag_clear = 2'b00;
      for (i = 0; i < 4 && ring_wake_out_n !== 1'b1; i++) @(negedge clk);
      chk({7'h00, ring_wake_out_n}, 8'h01, "wake release");
      if (ring_wake_out_n !== 1'b1) complete_run();
   endtask

   //------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------
   task automatic t_reset();
      chk({7'h00, ring_wake_out_n}, 8'h01, "wake idle");
      rdchk(CDG_IDX_CDGC_A, 8'h00, "socket a reset");
      rdchk(CDG_IDX_CDGC_B, 8'h00, "socket b reset");
      rdchk(CDG_IDX_GLOBAL, CDG_GLOBAL_RST, "global reset");
      $display("test reset done");
   endtask

   task automatic t_regs();
      wr(CDG_IDX_CDGC_A, 8'hff);
      rdchk(CDG_IDX_CDGC_A, 8'h12, "socket a fields");
      rdchk(CDG_IDX_CDGC_B, 8'h00, "socket b untouched");
      wr(CDG_IDX_GLOBAL, 8'hff);
      rdchk(CDG_IDX_GLOBAL, 8'h1f, "global writable bits");
      chk(global_ctrl, 8'h1f, "global copy");
      chk({7'h00, flag_clear_mode}, 8'h01, "clear mode");
      rdchk(8'h17, 8'h00, "unmapped index");
      wr(CDG_IDX_GLOBAL, 8'h00);
      chk({7'h00, flag_clear_mode}, 8'h00, "clear mode off");
      wr(CDG_IDX_CDGC_A, 8'h00);
      $display("test regs done");
   endtask

   // each sense code on socket a while socket b holds the inverse
   task automatic t_sense();
      for (int k = 0; k < 4; k++) begin
         sense1_set = {~k[0], k[0]};
         sense2_set = {~k[1], k[1]};
         rdchk(CDG_IDX_CDGC_A, {k[1], k[0], 6'h00}, "sense a");
         rdchk(CDG_IDX_CDGC_B, {~k[1], ~k[0], 6'h00}, "sense b");
      end
      sense1_set = 2'b00;
      sense2_set = 2'b00;
      $display("test sense done");
   endtask

   task automatic t_soft();
      cd_int_en = 2'b10;
      wr(CDG_IDX_CDGC_B, 8'h20);
      watch(4);
      chk(irq_cnt, 8'h10, "soft trigger b");
      cd_int_en = 2'b00;
      wr(CDG_IDX_CDGC_B, 8'h20);
      wr(CDG_IDX_CDGC_A, 8'h20);
      watch(4);
      chk(irq_cnt, 8'h00, "soft trigger disabled");
      cd_int_en = 2'b01;
      wr(CDG_IDX_GLOBAL, 8'h04);
      @(negedge clk);
      status_bit3_wr1 = 2'b01;
      @(negedge clk);
      status_bit3_wr1 = 2'b00;
      watch(4);
      chk(irq_cnt, 8'h00, "write-back clear quiet");
      wr(CDG_IDX_CDGC_A, 8'h20);
      watch(4);
      chk(irq_cnt, 8'h01, "soft trigger a");
      wr(CDG_IDX_GLOBAL, 8'h00);
      cd_int_en = 2'b00;
      $display("test soft done");
   endtask

   task automatic t_wake();
      wr(CDG_IDX_CDGC_A, 8'h12);
      seated = 2'b10; // removal on socket a
      watch(6);
      chk(rm_cnt, 8'h01, "removal reset pulse");
      chk({7'h00, ring_wake_out_n}, 8'h00, "wake on removal");
      watch(8);
      chk(hi_cnt, 8'h00, "wake held");
      clear_and_wait_high();
      seated = 2'b11; // card back in
      watch(6);
      chk(rm_cnt, 8'h00, "no pulse on insert");
      chk({7'h00, ring_wake_out_n}, 8'h00, "wake on insert");
      clear_and_wait_high();
      wr(CDG_IDX_CDGC_A, 8'h00);
      seated = 2'b00; // both sockets emptied with wake and reset off
      watch(8);
      chk(hi_cnt, 8'h08, "wake disabled");
      chk(rm_cnt, 8'h00, "removal reset off");
      $display("test wake done");
   endtask

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      {reg_idx, reg_wdata, reg_wr, reg_rd} = '0;
      {cd_int_en, cd_flag_clear, status_bit3_wr1, sense1_set, sense2_set} = '0;
      seated = 2'b11;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      t_reset();
      t_regs();
      t_sense();
      t_soft();
      t_wake();
      complete_run();
   end
endmodule
